// [hw/nhb_fifo.sv]
// Two-entry valid/ready buffer for read data
`timescale 1ns/10ps
`default_nettype none
module nhb_fifo
  import nhb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [NHB_BUS_W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [NHB_BUS_W-1:0] out_data_out
);
  logic [NHB_BUS_W-1:0] mem_r [NHB_FIFO_DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  assign in_ready_out = (count_r != 2'h2);
  assign out_valid_out = (count_r != 2'h0);
  assign out_data_out = mem_r[rd_ptr_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/nhb_host.sv]
// Host controller driving a strobe-timed flash bus
`timescale 1ns/10ps
`default_nettype none
module nhb_host
  import nhb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [1:0] req_op_in,
  input wire logic req_die_in,
  input wire logic req_wait_in,
  input wire logic [NHB_BUS_W-1:0] req_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [NHB_BUS_W-1:0] rd_data_out,
  input wire logic write_enable_in,
  input wire logic autoread_enable_in,
  output logic die0_select_n_out,
  output logic die1_select_n_out,
  output logic cmd_latch_out,
  output logic addr_latch_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic write_protect_n_out,
  output logic autoread_select_out,
  output logic [NHB_BUS_W-1:0] shared_io_bus_out,
  output logic shared_io_bus_oe_out,
  input wire logic [NHB_BUS_W-1:0] shared_io_bus_in,
  input wire logic ready_busy_n_in,
  output logic busy_out
);
  nhb_state_e state_r;
  logic [NHB_CNT_W-1:0] cnt_r;
  logic [1:0] op_r;
  logic die_r;
  logic wait_r;
  logic [NHB_BUS_W-1:0] data_r;
  logic fifo_ready;
  logic fifo_valid_r;
  logic [NHB_BUS_W-1:0] fifo_data_r;
  logic fifo_out_valid;
  logic [NHB_BUS_W-1:0] fifo_out_data;
  logic rd_pop;

  function automatic logic op_is_ctrl(input logic [1:0] op);
    op_is_ctrl = (op == NHB_OP_CMD) || (op == NHB_OP_ADDR);
  endfunction

  // Registered ready; trade-off: writes also wait while the read buffer is full
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (state_r == NHB_IDLE) && !(req_valid_in && req_ready_out) &&
                       fifo_ready;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= NHB_IDLE;
      cnt_r <= '0;
      op_r <= NHB_OP_CMD;
      die_r <= 1'b0;
      wait_r <= 1'b0;
      data_r <= '0;
    end else begin
      case (state_r)
        NHB_IDLE: begin
          if (req_valid_in && req_ready_out) begin
            op_r <= req_op_in;
            die_r <= req_die_in;
            wait_r <= req_wait_in;
            // Upper lanes forced low on command and address cycles
            data_r <= op_is_ctrl(req_op_in) ?
                      {8'h00, req_data_in[7:0] & NHB_LOW_BYTE_MASK} : req_data_in;
            cnt_r <= '0;
            state_r <= NHB_SETUP;
          end
        end
        NHB_SETUP: begin
          state_r <= NHB_LOW;
          cnt_r <= '0;
        end
        NHB_LOW: begin
          // Read low phase covers the access delay before sampling
          if ((op_r == NHB_OP_RDATA &&
               cnt_r == NHB_CNT_W'(NHB_READ_ACCESS_DELAY_CYC - 1)) ||
              (op_r != NHB_OP_RDATA &&
               cnt_r == NHB_CNT_W'(NHB_STROBE_LOW_CYC - 1))) begin
            state_r <= NHB_HIGH;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        NHB_HIGH: begin
          if (cnt_r == NHB_CNT_W'(NHB_STROBE_HIGH_CYC - 1)) begin
            state_r <= wait_r ? NHB_WAIT_RDY : NHB_IDLE;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        NHB_WAIT_RDY: begin
          // Only watch ready/busy until the operation ends
          if (ready_busy_n_in) begin
            state_r <= NHB_IDLE;
          end
        end
        default: state_r <= NHB_IDLE;
      endcase
    end
  end

  // Pin drive, all registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      die0_select_n_out <= 1'b1;
      die1_select_n_out <= 1'b1;
      cmd_latch_out <= 1'b0;
      addr_latch_out <= 1'b0;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      shared_io_bus_out <= '0;
      shared_io_bus_oe_out <= 1'b0;
    end else begin
      // Select released while waiting; the device ignores it when busy
      die0_select_n_out <= !((state_r == NHB_SETUP || state_r == NHB_LOW ||
                              state_r == NHB_HIGH) && !die_r);
      die1_select_n_out <= !((state_r == NHB_SETUP || state_r == NHB_LOW ||
                              state_r == NHB_HIGH) && die_r);
      cmd_latch_out <= (state_r != NHB_IDLE && state_r != NHB_WAIT_RDY) &&
                       op_r == NHB_OP_CMD;
      addr_latch_out <= (state_r != NHB_IDLE && state_r != NHB_WAIT_RDY) &&
                        op_r == NHB_OP_ADDR;
      write_strobe_n_out <= !(state_r == NHB_LOW && op_r != NHB_OP_RDATA);
      read_strobe_n_out <= !(state_r == NHB_LOW && op_r == NHB_OP_RDATA);
      shared_io_bus_out <= data_r;
      // Host bus drive only on writes, never while reading
      shared_io_bus_oe_out <= (state_r == NHB_SETUP || state_r == NHB_LOW ||
                               state_r == NHB_HIGH) && op_r != NHB_OP_RDATA;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_protect_n_out <= 1'b0;
      autoread_select_out <= 1'b0;
      busy_out <= 1'b1;
    end else begin
      // Protect stays asserted until software permits writes
      write_protect_n_out <= write_enable_in;
      autoread_select_out <= autoread_enable_in;
      busy_out <= (state_r != NHB_IDLE) || !ready_busy_n_in;
    end
  end

  // Sampled as the read strobe rises, a full access delay after its fall
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fifo_valid_r <= 1'b0;
      fifo_data_r <= '0;
    end else begin
      fifo_valid_r <= (state_r == NHB_HIGH) && op_r == NHB_OP_RDATA && cnt_r == '0;
      fifo_data_r <= shared_io_bus_in;
    end
  end

  nhb_fifo u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_valid_r),
    .in_ready_out(fifo_ready),
    .in_data_in(fifo_data_r),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(rd_pop),
    .out_data_out(fifo_out_data)
  );

  // Output register stage; pops only when empty or consumed
  assign rd_pop = fifo_out_valid && (!rd_valid_out || rd_ready_in);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else begin
      if (rd_pop) begin
        rd_valid_out <= 1'b1;
        rd_data_out <= fifo_out_data;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/nhb_pkg.sv]
// Package of constants for the flash host bus controller
package nhb_pkg;
  localparam int NHB_CLK_PERIOD_NS = 4;
  // Strobe low and high phase lengths
  localparam int NHB_STROBE_LOW_NS = 12;
  localparam int NHB_STROBE_HIGH_NS = 12;
  localparam int NHB_STROBE_LOW_CYC =
    (NHB_STROBE_LOW_NS + NHB_CLK_PERIOD_NS - 1) / NHB_CLK_PERIOD_NS;
  localparam int NHB_STROBE_HIGH_CYC =
    (NHB_STROBE_HIGH_NS + NHB_CLK_PERIOD_NS - 1) / NHB_CLK_PERIOD_NS;
  // Access delay from read strobe fall to valid data
  localparam int NHB_READ_ACCESS_DELAY_NS = 20;
  localparam int NHB_READ_ACCESS_DELAY_CYC =
    (NHB_READ_ACCESS_DELAY_NS + NHB_CLK_PERIOD_NS - 1) / NHB_CLK_PERIOD_NS;
  localparam int NHB_CNT_W = 4;
  localparam int NHB_BUS_W = 16;
  localparam int NHB_FIFO_DEPTH = 2;
  // Operation kinds on the request port
  localparam logic [1:0] NHB_OP_CMD = 2'h0;
  localparam logic [1:0] NHB_OP_ADDR = 2'h1;
  localparam logic [1:0] NHB_OP_WDATA = 2'h2;
  localparam logic [1:0] NHB_OP_RDATA = 2'h3;
  localparam logic [7:0] NHB_LOW_BYTE_MASK = 8'hff;
  typedef enum logic [4:0] {
    NHB_IDLE = 5'h01,
    NHB_SETUP = 5'h02,
    NHB_LOW = 5'h04,
    NHB_HIGH = 5'h08,
    NHB_WAIT_RDY = 5'h10
  } nhb_state_e;
endpackage

// [testbench/nhb_dev_model.sv]
// Behavioural flash device on the strobe bus
`timescale 1ns/10ps
`default_nettype none
module nhb_dev_model import nhb_pkg::*; (
  input wire logic s0_n_in,
  input wire logic s1_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic rs_n_in,
  input wire logic wp_n_in,
  input wire logic autoread_in,
  input wire logic oe_in,
  input wire logic [15:0] hd_in,
  output logic [15:0] lvl_out,
  output logic rb_n_out
);
  logic [15:0] mem [256];
  logic [15:0] pb [256];
  logic [15:0] dq;
  logic [7:0] col, idx, cmd;
  logic drv;
  wire logic sel = !(s0_n_in && s1_n_in);
  wire logic standby = !sel && rb_n_out;
  // Released or standby bus shows the inverse of the last word, never a stale match
  assign lvl_out = oe_in ? hd_in : ((drv && !standby) ? dq : ~dq);
  initial begin
    drv = 0;
    dq = 0;
    rb_n_out = 1;
    col = 8'hff; // Off page zero until the autoread moves it there
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h3c00 ^ 16'(i);
      pb[i] = mem[i];
    end
  end
  always @(posedge autoread_in) col = 8'h00;
  always @(posedge we_n_in) if (sel) begin
    if (cle_in) begin
      cmd = hd_in[7:0];
      // Program commits the page buffer only when not protected
      if (cmd == 8'h10 && wp_n_in) for (int i = 0; i < 256; i++) mem[i] = pb[i];
      if (cmd == 8'h30 || (cmd == 8'h10 && wp_n_in)) begin
        rb_n_out = 0;
        #100 rb_n_out = 1;
      end
    end else if (ale_in) col = hd_in[7:0];
    else begin
      pb[col] = hd_in;
      col++;
    end
  end
  // Data settles just short of the full access delay, so an early sample sees the inverse
  always @(negedge rs_n_in) if (sel) begin
    idx = col;
    dq = ~mem[idx];
    drv = 1;
    col++;
    #(NHB_READ_ACCESS_DELAY_NS - 1) dq = mem[idx];
  end
  always @(posedge rs_n_in) drv = 0;
endmodule
`default_nettype wire

// [testbench/nhb_host_sva.sv]
// Protocol assertions for the flash host bus controller
`timescale 1ns/10ps
`default_nettype none
module nhb_host_sva import nhb_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic write_enable_in,
  input wire logic die0_select_n_out,
  input wire logic die1_select_n_out,
  input wire logic cmd_latch_out,
  input wire logic addr_latch_out,
  input wire logic write_strobe_n_out,
  input wire logic read_strobe_n_out,
  input wire logic write_protect_n_out,
  input wire logic [NHB_BUS_W-1:0] shared_io_bus_out,
  input wire logic shared_io_bus_oe_out,
  input wire logic ready_busy_n_in,
  input wire logic busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence wr_low_s;
    (!write_strobe_n_out && $stable(shared_io_bus_out))[*3] ##1 write_strobe_n_out;
  endsequence
  sequence rd_low_s;
    (!read_strobe_n_out && !shared_io_bus_oe_out)[*5] ##1 read_strobe_n_out;
  endsequence
  wr_pulse_a: assert property ($fell(write_strobe_n_out) |-> wr_low_s)
    else $error("write strobe pulse malformed");
  rd_pulse_a: assert property ($fell(read_strobe_n_out) |-> rd_low_s)
    else $error("read strobe pulse malformed");
  upper_zero_a: assert property ((cmd_latch_out || addr_latch_out) && shared_io_bus_oe_out
    |-> shared_io_bus_out[15:8] == 8'h00) else $error("upper byte not low");
  latch_excl_a: assert property (!(cmd_latch_out && addr_latch_out))
    else $error("both latches high");
  one_die_a: assert property (!(write_strobe_n_out && read_strobe_n_out)
    |-> $onehot({die0_select_n_out, die1_select_n_out})) else $error("die select wrong");
  wr_drive_a: assert property (!write_strobe_n_out |-> shared_io_bus_oe_out)
    else $error("bus not driven on write");
  wp_follow_a: assert property (!$past(rst_in)
    |-> write_protect_n_out == $past(write_enable_in)) else $error("protect mismatch");
  busy_track_a: assert property (!ready_busy_n_in |=> busy_out)
    else $error("busy not reported");
endmodule
bind nhb_host nhb_host_sva chk_u (.clk_in, .rst_in, .write_enable_in, .die0_select_n_out,
  .die1_select_n_out, .cmd_latch_out, .addr_latch_out, .write_strobe_n_out,
  .read_strobe_n_out, .write_protect_n_out, .shared_io_bus_out, .shared_io_bus_oe_out,
  .ready_busy_n_in, .busy_out);
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the flash host bus controller
`timescale 1ns/10ps
`default_nettype none
module testbench import nhb_pkg::*;;
  logic clk_in = 0, rst_in = 1, req_valid_in = 0, req_die_in = 0, req_wait_in = 0;
  logic rd_ready_in = 0, write_enable_in = 1, autoread_enable_in = 1;
  logic req_ready_out, rd_valid_out, s0_n, s1_n, cle, ale, we_n, rs_n, wp_n, oe, rb_n, busy_out;
  logic ar_sel;
  logic [1:0] req_op_in = 0;
  logic [15:0] req_data_in = 0, rd_data_out, hd, lvl, e;
  logic [15:0] exp_q [$];
  logic [15:0] wd [3];
  int n_fail = 0, samples_checked = 0;
  always #2 clk_in = ~clk_in;
  nhb_host dut_u (.clk_in, .rst_in, .req_valid_in, .req_ready_out, .req_op_in, .req_die_in,
    .req_wait_in, .req_data_in, .rd_valid_out, .rd_ready_in, .rd_data_out, .write_enable_in,
    .autoread_enable_in, .die0_select_n_out(s0_n), .die1_select_n_out(s1_n),
    .cmd_latch_out(cle), .addr_latch_out(ale), .write_strobe_n_out(we_n),
    .read_strobe_n_out(rs_n), .write_protect_n_out(wp_n), .autoread_select_out(ar_sel),
    .shared_io_bus_out(hd), .shared_io_bus_oe_out(oe), .shared_io_bus_in(lvl),
    .ready_busy_n_in(rb_n), .busy_out);
  nhb_dev_model dev_u (.s0_n_in(s0_n), .s1_n_in(s1_n), .cle_in(cle), .ale_in(ale),
    .we_n_in(we_n), .rs_n_in(rs_n), .wp_n_in(wp_n), .autoread_in(ar_sel), .oe_in(oe),
    .hd_in(hd), .lvl_out(lvl), .rb_n_out(rb_n));
  task automatic req(input logic [1:0] op, input logic [15:0] d, input logic w);
    req_op_in = op;
    req_data_in = d;
    req_wait_in = w;
    req_valid_in = 1;
    if (op == NHB_OP_RDATA) exp_q.push_back(d);
    while (req_ready_out !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
    #1 req_valid_in = 0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Random stalls drop rd_ready_in about one cycle in three, so read data waits in the output register
  always @(posedge clk_in) begin
    if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1) begin
      samples_checked++;
      e = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
      if (rd_data_out !== e) begin
        n_fail++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, rd_data_out, e);
      end
    end
    #1 rd_ready_in = ($urandom % 3) != 0;
  end
  initial begin
    #20000 n_fail++;
    results();
  end
  initial begin
    void'($urandom(48031));
    repeat (5) @(posedge clk_in);
    #1 rst_in = 0;
    req(NHB_OP_RDATA, 16'h3c00, 0);
    for (int d = 0; d < 2; d++) begin
      req_die_in = d[0];
      foreach (wd[i]) wd[i] = 16'($urandom);
      req(NHB_OP_CMD, 16'h0080, 0);
      req(NHB_OP_ADDR, 16'h0040 + 16'(d), 0);
      foreach (wd[i]) req(NHB_OP_WDATA, wd[i], 0);
      req(NHB_OP_CMD, 16'h0010, 1);
      req(NHB_OP_CMD, 16'h0000, 0);
      req(NHB_OP_ADDR, 16'h0040 + 16'(d), 0);
      req(NHB_OP_CMD, 16'h0030, 1);
      foreach (wd[i]) req(NHB_OP_RDATA, wd[i], 0);
    end
    write_enable_in = 0;
    req(NHB_OP_CMD, 16'h0080, 0);
    req(NHB_OP_ADDR, 16'h0044, 0);
    req(NHB_OP_WDATA, ~16'h3c44, 0);
    req(NHB_OP_CMD, 16'h0010, 1);
    req(NHB_OP_CMD, 16'h0000, 0);
    req(NHB_OP_ADDR, 16'h0044, 0);
    req(NHB_OP_CMD, 16'h0030, 1);
    req(NHB_OP_RDATA, 16'h3c44, 0);
    wait (exp_q.size() == 0);
    repeat (4) @(posedge clk_in);
    results();
  end
endmodule
`default_nettype wire
